/* rtl/ring_station.sv */
`timescale 1ns/1ns
`default_nettype none
module ring_station #(
    parameter logic [31:0] ROT_DEFAULT = ring_frame_pkg::ROT_DEFAULT_US
) (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // link
    ring_link_if.station link,
    // timer restore and value
    input wire logic i_restore,
    input wire logic i_rot_load,
    input wire logic [31:0] i_rot_value,
    output logic [31:0] o_rot_time,
    // transmit request
    input wire logic i_tx_start,
    input wire logic [7:0] i_tx_fc,
    input wire logic [ring_frame_pkg::ADDR_BITS-1:0] i_tx_da,
    input wire logic [ring_frame_pkg::ADDR_BITS-1:0] i_tx_sa,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_last,
    output logic o_tx_ready,
    output logic o_tx_busy,
    output logic o_tx_refused,
    // receive
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_rx_sof,
    output logic o_rx_eof,
    output logic o_rx_fcs_ok,
    output logic o_rx_too_long,
    output logic o_rx_token
);
    import ring_frame_pkg::*;
    typedef enum logic [7:0] {
        T_IDLE = 8'h01, T_PRE = 8'h02, T_HDR = 8'h04, T_INFO = 8'h08,
        T_FCS = 8'h10, T_END = 8'h20, T_STAT = 8'h40, T_DONE = 8'h80
    } tx_e;
    tx_e st_ff, nxt_st;
    logic [4:0] cnt_ff, nxt_cnt;
    logic hi_ff, nxt_hi;
    logic [7:0] byte_ff, nxt_byte;
    logic [31:0] crc_ff, nxt_crc;
    logic [111:0] hdr_ff, nxt_hdr;
    symbol_t txs_ff, nxt_txs;
    logic [13:0] info_ff, nxt_info;
    logic [31:0] rot_ff, nxt_rot;
    logic refused_ff, nxt_refused;
    symbol_t rx1_ff, rx2_ff;
    always_comb begin
        nxt_rot = rot_ff;
        if (i_restore) begin
            nxt_rot = ROT_DEFAULT; // [RULE_03] [RULE_02]
        end else if (i_rot_load) begin
            nxt_rot = i_rot_value;
        end
    end
    // transmit framer: 16 idle, JK, FC+DA+SA, info, FCS, T, status
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_hi = hi_ff;
        nxt_byte = byte_ff;
        nxt_crc = crc_ff;
        nxt_hdr = hdr_ff;
        nxt_txs = SYM_IDLE;
        nxt_info = info_ff;
        nxt_refused = 1'b0;
        o_tx_ready = 1'b0;
        case (st_ff)
            T_IDLE: begin
                if (i_tx_start) begin
                    if ((i_tx_fc & FC_TOKEN_MASK) == FC_RESTRICTED_TOKEN) begin
                        nxt_refused = 1'b1; // [RULE_05]
                    end else begin
                        nxt_st = T_PRE;
                        nxt_cnt = 5'(TX_PREAMBLE - 1);
                        nxt_hdr = {i_tx_fc, i_tx_da, i_tx_sa, 8'h00}; // [RULE_01] [RULE_08]
                        nxt_crc = CRC_INIT;
                        nxt_info = '0;
                    end
                end
            end
            T_PRE: begin
                if (cnt_ff == 5'h0) begin
                    nxt_txs = SYM_J; // [RULE_06] [RULE_07]
                    nxt_st = T_HDR;
                    nxt_cnt = 5'(1 + 2 * ADDR_BYTES);
                    nxt_hi = 1'b0;
                end else begin
                    nxt_cnt = cnt_ff - 5'h1;
                end
            end
            T_HDR: begin
                if (txs_ff == SYM_J) begin
                    nxt_txs = SYM_K; // [RULE_07]
                end else if (!hi_ff) begin
                    nxt_txs = {1'b0, hdr_ff[111:108]};
                    nxt_hi = 1'b1;
                end else begin
                    nxt_txs = {1'b0, hdr_ff[107:104]}; // [RULE_15]
                    nxt_crc = crc_byte(crc_ff, hdr_ff[111:104]); // [RULE_10]
                    nxt_hdr = {hdr_ff[103:0], 8'h00};
                    nxt_hi = 1'b0;
                    nxt_cnt = cnt_ff - 5'h1;
                    if (cnt_ff == 5'h1) begin
                        nxt_st = T_INFO;
                    end
                end
            end
            T_INFO: begin
                if (!hi_ff) begin
                    o_tx_ready = 1'b1;
                    if (i_tx_valid) begin
                        nxt_byte = i_tx_data;
                        nxt_txs = {1'b0, i_tx_data[7:4]};
                        nxt_hi = 1'b1;
                        nxt_crc = crc_byte(crc_ff, i_tx_data);
                        nxt_info = info_ff + 14'h1;
                        // last byte accepted also ends the field at the byte limit
                        if (i_tx_last || info_ff == 14'(INFO_MAX_BYTES - 1)) begin
                            nxt_cnt = 5'h1F; // [RULE_04] [RULE_09]
                        end
                    end else begin
                        nxt_txs = SYM_IDLE;
                    end
                end else begin
                    nxt_txs = {1'b0, byte_ff[3:0]};
                    nxt_hi = 1'b0;
                    if (cnt_ff == 5'h1F) begin
                        nxt_st = T_FCS;
                        nxt_cnt = 5'(2 * FCS_BYTES - 1);
                    end
                end
            end
            T_FCS: begin
                // each check byte goes out high nibble first, like data
                if (cnt_ff[0]) begin
                    nxt_txs = {1'b0, ~crc_ff[7:4]}; // [RULE_10] [RULE_15]
                end else begin
                    nxt_txs = {1'b0, ~crc_ff[3:0]};
                    nxt_crc = {8'h00, crc_ff[31:8]};
                end
                nxt_cnt = cnt_ff - 5'h1;
                if (cnt_ff == 5'h0) begin
                    nxt_st = T_END;
                end
            end
            T_END: begin
                nxt_txs = SYM_T; // [RULE_11]
                nxt_st = T_STAT;
                nxt_cnt = 5'(STATUS_SYMBOLS - 1);
            end
            T_STAT: begin
                nxt_txs = SYM_R; // [RULE_11]
                nxt_cnt = cnt_ff - 5'h1;
                if (cnt_ff == 5'h0) begin
                    nxt_st = T_DONE;
                end
            end
            default: begin
                nxt_st = T_IDLE;
            end
        endcase
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_ff <= T_IDLE;
            cnt_ff <= '0;
            hi_ff <= 1'b0;
            byte_ff <= '0;
            crc_ff <= CRC_INIT;
            hdr_ff <= '0;
            txs_ff <= SYM_IDLE;
            info_ff <= '0;
            rot_ff <= ROT_DEFAULT;
            refused_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            hi_ff <= nxt_hi;
            byte_ff <= nxt_byte;
            crc_ff <= nxt_crc;
            hdr_ff <= nxt_hdr;
            txs_ff <= nxt_txs;
            info_ff <= nxt_info;
            rot_ff <= nxt_rot;
            refused_ff <= nxt_refused;
        end
    end
    assign link.sym_a = txs_ff;
    assign o_rot_time = rot_ff;
    assign o_tx_busy = (st_ff != T_IDLE);
    assign o_tx_refused = refused_ff;
    // receive: two-stage capture of the ring symbols
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            rx1_ff <= SYM_IDLE;
            rx2_ff <= SYM_IDLE;
        end else begin
            rx1_ff <= link.sym_b;
            rx2_ff <= rx1_ff;
        end
    end
    ring_deframer u_rx (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_sym(rx2_ff),
        .i_min_preamble(5'(COPY_PREAMBLE)),
        .o_valid(o_rx_valid),
        .o_data(o_rx_data),
        .o_sof(o_rx_sof),
        .o_eof(o_rx_eof),
        .o_fcs_ok(o_rx_fcs_ok),
        .o_too_long(o_rx_too_long),
        .o_token(o_rx_token)
    );
endmodule
`default_nettype wire

/* common/ring_frame_pkg.sv */
// Contract
// RULE_01 - addresses are 48 bits wide
// RULE_02 - default rotation time between 165 and 200 ms
// RULE_03 - restore input returns timer defaults
// RULE_04 - info field 0 to 4478 bytes; the transmit framer always sends at least 1
// RULE_05 - never issue or capture restricted tokens
// RULE_06 - send 16 idles; copy needs 12, repeat 2
// RULE_07 - JK start delimiter then two-symbol control
// RULE_08 - destination then source, 12 symbols each
// RULE_09 - info over 8956 symbols is flagged
// RULE_10 - 8-symbol check sequence, generated and checked
// RULE_11 - one-symbol end delimiter, three status symbols
// RULE_12 - station repeat delay under one microsecond
// RULE_13 - concentrator repeat delay one microsecond per port
// RULE_14 - budget 1.164 microseconds per physical layer
// RULE_15 - four bits per symbol, byte is pair
`default_nettype none
package ring_frame_pkg;
    localparam int CLOCK_MHZ = 250;
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    // control codes keep bit 4 set, apart from the data nibbles
    localparam logic [4:0] SYM_T = 5'h1D;
    localparam logic [4:0] SYM_R = 5'h17;
    localparam logic [4:0] SYM_S = 5'h19;
    localparam int TX_PREAMBLE = 16;
    localparam int COPY_PREAMBLE = 12;
    localparam int REPEAT_PREAMBLE = 2;
    localparam int ADDR_BITS = 48;
    localparam int ADDR_BYTES = 6;
    localparam int INFO_MAX_BYTES = 4478;
    localparam int INFO_MAX_SYMBOLS = 8956;
    localparam int FCS_BYTES = 4;
    localparam int STATUS_SYMBOLS = 3;
    localparam logic [7:0] FC_RESTRICTED_TOKEN = 8'h80;
    localparam logic [7:0] FC_TOKEN_MASK = 8'hF0;
    localparam int ROT_MIN_MS = 165;
    localparam int ROT_MAX_MS = 200;
    localparam logic [31:0] ROT_DEFAULT_US = 32'h0002_DF24;
    localparam int REPEAT_DELAY_NS = 1000;
    localparam int REPEAT_DELAY_CYC = REPEAT_DELAY_NS * CLOCK_MHZ / 1000;
    localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
    localparam logic [31:0] CRC_GOOD = 32'hDEBB_20E3;
    typedef logic [4:0] symbol_t;
    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage
`default_nettype wire

/* common/ring_link_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface ring_link_if;
    import ring_frame_pkg::*;
    symbol_t sym_a;
    symbol_t sym_b;
    modport station (output sym_a, input sym_b);
    modport neighbour (input sym_a, output sym_b);
endinterface
`default_nettype wire

/* rtl/ring_neighbour.sv */
`timescale 1ns/1ns
`default_nettype none
module ring_neighbour (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // link
    ring_link_if.neighbour link,
    // symbols injected by the neighbour when not repeating
    input wire logic i_inject,
    input wire ring_frame_pkg::symbol_t i_inject_sym,
    // monitor of repeated frames
    output logic o_frame_seen,
    output logic o_fcs_ok
);
    import ring_frame_pkg::*;
    symbol_t s1_ff, s2_ff, out_ff, nxt_out;
    logic seen_nc, ok_nc, eof_nc;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s1_ff <= SYM_IDLE;
            s2_ff <= SYM_IDLE;
        end else begin
            s1_ff <= link.sym_a;
            s2_ff <= s1_ff;
        end
    end
    // repeat path: three cycles, well inside the one-microsecond budget
    always_comb begin
        nxt_out = i_inject ? i_inject_sym : s2_ff; // [RULE_12] [RULE_13] [RULE_14]
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            out_ff <= SYM_IDLE;
        end else begin
            out_ff <= nxt_out;
        end
    end
    assign link.sym_b = out_ff;
    ring_deframer u_mon (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_sym(s2_ff),
        .i_min_preamble(5'(REPEAT_PREAMBLE)), // [RULE_06]
        .o_valid(),
        .o_data(),
        .o_sof(seen_nc),
        .o_eof(eof_nc),
        .o_fcs_ok(ok_nc),
        .o_too_long(),
        .o_token()
    );
    logic seen_ff, ok_ff;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            seen_ff <= 1'b0;
            ok_ff <= 1'b0;
        end else begin
            seen_ff <= seen_nc;
            ok_ff <= eof_nc ? ok_nc : ok_ff; // [RULE_10] [RULE_01] [RULE_08] [RULE_11]
        end
    end
    assign o_frame_seen = seen_ff;
    assign o_fcs_ok = ok_ff;
endmodule

module ring_deframer (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // symbol stream
    input wire ring_frame_pkg::symbol_t i_sym,
    input wire logic [4:0] i_min_preamble,
    // bytes out
    output logic o_valid,
    output logic [7:0] o_data,
    output logic o_sof,
    output logic o_eof,
    output logic o_fcs_ok,
    output logic o_too_long,
    output logic o_token
);
    import ring_frame_pkg::*;
    // header is 13 bytes, check is 4; info beyond the limit is flagged
    localparam int BODY_MAX_BYTES = INFO_MAX_BYTES + 2 * ADDR_BYTES + 1 + FCS_BYTES;
    typedef enum logic [3:0] {R_IDLE = 4'h1, R_J = 4'h2, R_BODY = 4'h4, R_END = 4'h8} rx_e;
    rx_e st_ff, nxt_st;
    logic [4:0] pre_ff, nxt_pre;
    logic hi_ff, nxt_hi;
    logic [3:0] nib_ff, nxt_nib;
    logic [31:0] crc_ff, nxt_crc;
    logic [14:0] len_ff, nxt_len;
    logic v_ff, nxt_v, sof_ff, nxt_sof, eof_ff, nxt_eof, ok_ff, nxt_ok, long_ff, nxt_long;
    logic tok_ff, nxt_tok, first_ff, nxt_first;
    logic [7:0] d_ff, nxt_d;
    always_comb begin
        nxt_st = st_ff;
        nxt_pre = pre_ff;
        nxt_hi = hi_ff;
        nxt_nib = nib_ff;
        nxt_crc = crc_ff;
        nxt_len = len_ff;
        nxt_v = 1'b0;
        nxt_sof = 1'b0;
        nxt_eof = 1'b0;
        nxt_ok = ok_ff;
        nxt_long = long_ff;
        nxt_tok = 1'b0;
        nxt_first = first_ff;
        nxt_d = d_ff;
        case (st_ff)
            R_IDLE: begin
                if (i_sym == SYM_IDLE) begin
                    nxt_pre = (pre_ff == 5'h1F) ? pre_ff : pre_ff + 5'h1;
                end else if (i_sym == SYM_J && pre_ff >= i_min_preamble) begin
                    nxt_st = R_J; // [RULE_06]
                end else begin
                    nxt_pre = '0;
                end
            end
            R_J: begin
                nxt_pre = '0;
                nxt_st = (i_sym == SYM_K) ? R_BODY : R_IDLE; // [RULE_07]
                nxt_hi = 1'b0;
                nxt_crc = CRC_INIT;
                nxt_len = '0;
                nxt_long = 1'b0;
                nxt_first = 1'b1;
            end
            R_BODY: begin
                if (i_sym == SYM_T) begin
                    nxt_st = R_END; // [RULE_11]
                    nxt_eof = 1'b1;
                    nxt_ok = (crc_ff == CRC_GOOD); // [RULE_10]
                    nxt_long = (len_ff > 15'(BODY_MAX_BYTES)); // [RULE_09] [RULE_04]
                    nxt_tok = first_ff; // [RULE_05]
                end else if (!i_sym[4]) begin
                    if (!hi_ff) begin
                        nxt_nib = i_sym[3:0];
                        nxt_hi = 1'b1;
                    end else begin
                        nxt_d = {nib_ff, i_sym[3:0]}; // [RULE_15]
                        nxt_v = 1'b1;
                        nxt_sof = first_ff;
                        nxt_first = 1'b0;
                        nxt_hi = 1'b0;
                        nxt_crc = crc_byte(crc_ff, {nib_ff, i_sym[3:0]});
                        nxt_len = (len_ff == 15'h7FFF) ? len_ff : len_ff + 15'h1;
                    end
                end else begin
                    nxt_st = R_IDLE;
                end
            end
            default: begin
                if (i_sym == SYM_IDLE) begin
                    nxt_st = R_IDLE;
                    nxt_pre = 5'h1;
                end
            end
        endcase
    end
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            st_ff <= R_IDLE;
            pre_ff <= '0;
            hi_ff <= 1'b0;
            nib_ff <= '0;
            crc_ff <= CRC_INIT;
            len_ff <= '0;
            v_ff <= 1'b0;
            sof_ff <= 1'b0;
            eof_ff <= 1'b0;
            ok_ff <= 1'b0;
            long_ff <= 1'b0;
            tok_ff <= 1'b0;
            first_ff <= 1'b0;
            d_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            pre_ff <= nxt_pre;
            hi_ff <= nxt_hi;
            nib_ff <= nxt_nib;
            crc_ff <= nxt_crc;
            len_ff <= nxt_len;
            v_ff <= nxt_v;
            sof_ff <= nxt_sof;
            eof_ff <= nxt_eof;
            ok_ff <= nxt_ok;
            long_ff <= nxt_long;
            tok_ff <= nxt_tok;
            first_ff <= nxt_first;
            d_ff <= nxt_d;
        end
    end
    assign o_valid = v_ff;
    assign o_data = d_ff;
    assign o_sof = sof_ff;
    assign o_eof = eof_ff;
    assign o_fcs_ok = ok_ff;
    assign o_too_long = long_ff;
    assign o_token = tok_ff;
endmodule
`default_nettype wire

/* verif/token_ring_mac_framing_properties.sv */
`timescale 1ns/1ns
`default_nettype none
module token_ring_mac_framing_properties (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // link symbols
    input wire ring_frame_pkg::symbol_t sym_a,
    input wire ring_frame_pkg::symbol_t sym_b
);
    import ring_frame_pkg::*;
    localparam int REP_MAX = REPEAT_DELAY_CYC;
    localparam int MIN_BODY = 2 * (1 + 2 * ADDR_BYTES + FCS_BYTES);
    localparam int MAX_BODY = MIN_BODY + INFO_MAX_SYMBOLS;
    logic [4:0] idle_ff;
    logic [13:0] body_ff;
    logic frame_ff;
    // idle run length and data symbol count of the outgoing frame
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            idle_ff <= 5'h00;
            body_ff <= 14'h0000;
            frame_ff <= 1'b0;
        end else begin
            idle_ff <= (sym_a != SYM_IDLE) ? 5'h00 : idle_ff + {4'h0, idle_ff != 5'h1F};
            body_ff <= (sym_a == SYM_K) ? 14'h0000 : body_ff + {13'h0000, frame_ff};
            frame_ff <= (sym_a == SYM_K) || (frame_ff && sym_a != SYM_T);
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence s_sd;
        sym_a == SYM_J ##1 sym_a == SYM_K;
    endsequence
    sequence s_fs;
        (sym_a == SYM_R) [*3];
    endsequence
    property p_preamble;
        sym_a == SYM_J |-> idle_ff >= 5'(TX_PREAMBLE);
    endproperty
    property p_sd;
        sym_a == SYM_J |=> sym_a == SYM_K;
    endproperty
    property p_unrestricted;
        s_sd |=> sym_a != {1'b0, FC_RESTRICTED_TOKEN[7:4]};
    endproperty
    property p_status;
        sym_a == SYM_T |=> s_fs;
    endproperty
    property p_nibble;
        frame_ff && sym_a != SYM_T |-> !sym_a[4];
    endproperty
    property p_min_len;
        sym_a == SYM_T |-> body_ff >= 14'(MIN_BODY);
    endproperty
    property p_max_len;
        sym_a == SYM_T |-> body_ff <= 14'(MAX_BODY);
    endproperty
    property p_repeat;
        sym_a == SYM_J |-> ##[1:REP_MAX] sym_b == SYM_J;
    endproperty
    a_preamble: assert property (p_preamble) else $error("short preamble");
    a_sd: assert property (p_sd) else $error("J not followed by K");
    a_unrestricted: assert property (p_unrestricted) else $error("restricted token");
    a_status: assert property (p_status) else $error("bad frame status");
    a_nibble: assert property (p_nibble) else $error("non data symbol");
    a_min_len: assert property (p_min_len) else $error("frame too short");
    a_max_len: assert property (p_max_len) else $error("frame too long");
    a_repeat: assert property (p_repeat) else $error("repeat too slow");
endmodule
`default_nettype wire

/* verif/token_ring_mac_framing_test.sv */
`timescale 1ns/1ns
`default_nettype none
module token_ring_mac_framing_test;
    import ring_frame_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic restore = 1'b0, rot_load = 1'b0, start = 1'b0, valid = 1'b0, last = 1'b0;
    logic inject = 1'b0, grab = 1'b0, long_seen, ready, busy, refused, rx_valid;
    logic rx_sof, rx_eof, fcs_ok, too_long, token, frame_seen, nb_fcs_ok;
    logic [31:0] rot_value = 32'h0, rot_time, rng = 32'h30;
    logic [7:0] fc = 8'h00, data = 8'h00, rx_data;
    logic [47:0] da = 48'h0, sa = 48'h0;
    symbol_t inj_sym = SYM_IDLE;
    int fails = 0, check_count = 0, eofs = 0, tokens = 0, sofs = 0, js = 0, seens = 0;
    logic [7:0] info [$];
    logic [7:0] rq [$];
    symbol_t wq [$];
    ring_link_if ring_link_if_inst ();
    ring_station ring_station_inst (.i_clock(i_clock), .i_reset(i_reset),
        .link(ring_link_if_inst), .i_restore(restore), .i_rot_load(rot_load),
        .i_rot_value(rot_value), .o_rot_time(rot_time), .i_tx_start(start), .i_tx_fc(fc),
        .i_tx_da(da), .i_tx_sa(sa), .i_tx_valid(valid), .i_tx_data(data), .i_tx_last(last),
        .o_tx_ready(ready), .o_tx_busy(busy), .o_tx_refused(refused), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data), .o_rx_sof(rx_sof), .o_rx_eof(rx_eof), .o_rx_fcs_ok(fcs_ok),
        .o_rx_too_long(too_long), .o_rx_token(token));
    ring_neighbour ring_neighbour_inst (.i_clock(i_clock), .i_reset(i_reset),
        .link(ring_link_if_inst), .i_inject(inject), .i_inject_sym(inj_sym),
        .o_frame_seen(frame_seen), .o_fcs_ok(nb_fcs_ok));
    token_ring_mac_framing_properties token_ring_mac_framing_properties_inst (
        .i_clock(i_clock), .i_reset(i_reset), .sym_a(ring_link_if_inst.sym_a),
        .sym_b(ring_link_if_inst.sym_b));
    initial begin
        forever #2 i_clock = ~i_clock;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
        check_count++;
        if (seen_v !== exp_v) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen_v, exp_v);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // receive side and wire monitor, sampled away from the active edge
    always @(negedge i_clock) begin
        if (rx_sof === 1'b1) begin
            rq.delete();
            sofs++;
        end
        if (rx_valid === 1'b1) rq.push_back(rx_data);
        if (rx_eof === 1'b1) begin
            eofs++;
            long_seen = too_long;
        end
        if (token === 1'b1) tokens++;
        if (frame_seen === 1'b1) seens++;
        if (ring_link_if_inst.sym_a === SYM_J) begin
            js++;
            grab = 1'b1;
            wq.delete();
        end else if (grab) begin
            wq.push_back(ring_link_if_inst.sym_a);
            if (ring_link_if_inst.sym_a === SYM_T) grab = 1'b0;
        end
    end
    task automatic wait_idle(input int e0);
        int k;
        k = 0;
        while ((busy !== 1'b0 || eofs == e0) && k < 20000) begin
            @(posedge i_clock);
            #2;
            k++;
        end
        if (k >= 20000) fails++;
    endtask
    task automatic send(input logic [7:0] f, input int n);
        int k;
        int e0;
        int s0;
        e0 = eofs;
        s0 = seens;
        info.delete();
        for (int i = 0; i < n; i++) begin
            rng = xs(rng);
            info.push_back(rng[7:0]);
        end
        @(posedge i_clock);
        #1;
        start = 1'b1;
        fc = f;
        da = {rng[15:0], xs(rng)};
        sa = ~da;
        @(posedge i_clock);
        #1;
        start = 1'b0;
        for (int i = 0; i < n; i++) begin
            valid = 1'b1;
            data = info[i];
            last = (i == n - 1);
            #1;
            k = 0;
            while (ready !== 1'b1 && k < 100) begin
                @(posedge i_clock);
                #2;
                k++;
            end
            if (k >= 100) fails++;
            @(posedge i_clock);
            #1;
        end
        valid = 1'b0;
        last = 1'b0;
        wait_idle(e0);
        check(seens - s0, 1);
        check(wq.size(), 36 + 2 * n);
        check(wq[0], SYM_K);
        check({wq[1][3:0], wq[2][3:0]}, f);
        check(wq[wq.size() - 1], SYM_T);
        check(rq[0], f);
        for (int i = 0; i < n; i++) begin
            check({wq[27 + 2 * i][3:0], wq[28 + 2 * i][3:0]}, info[i]);
            check(rq[13 + i], info[i]);
        end
        check(fcs_ok, 1'b1);
        check(nb_fcs_ok, 1'b1);
        check(long_seen, 1'b0);
    endtask
    // neighbour overrides its repeat path with a hand-built frame
    task automatic inj_frame(input int idl, input int nd);
        symbol_t s [$];
        // a non-idle symbol first, so only idl idles count as preamble
        s.push_back(SYM_R);
        for (int i = 0; i < idl; i++) s.push_back(SYM_IDLE);
        s.push_back(SYM_J);
        s.push_back(SYM_K);
        for (int i = 0; i < nd; i++) s.push_back(5'h05);
        s.push_back(SYM_T);
        for (int i = 0; i < 3; i++) s.push_back(SYM_R);
        inject = 1'b1;
        foreach (s[i]) begin
            inj_sym = s[i];
            @(posedge i_clock);
            #1;
        end
        inject = 1'b0;
        inj_sym = SYM_IDLE;
        repeat (30) @(posedge i_clock);
        #1;
    endtask
    initial begin
        int k;
        int c0;
        repeat (3) @(posedge i_clock);
        #1;
        i_reset = 1'b0;
        check(rot_time >= 32'h0002_84C8 && rot_time <= 32'h0003_0D40, 1'b1);
        send(8'h50, 1);
        for (int r = 0; r < 3; r++) begin
            rng = xs(rng);
            send({1'b0, rng[6:0]}, 2 + rng[12:8]);
        end
        send(8'hC3, INFO_MAX_BYTES);
        c0 = js;
        @(posedge i_clock);
        #1;
        start = 1'b1;
        fc = 8'h8C;
        @(posedge i_clock);
        #1;
        start = 1'b0;
        k = 0;
        repeat (4) begin
            @(negedge i_clock);
            if (refused === 1'b1) k++;
        end
        check(k, 1);
        repeat (40) @(posedge i_clock);
        #1;
        check(js - c0, 0);
        check(busy, 1'b0);
        rng = xs(rng);
        rot_load = 1'b1;
        rot_value = rng;
        @(posedge i_clock);
        #1;
        rot_load = 1'b0;
        @(posedge i_clock);
        #1;
        check(rot_time, rot_value);
        restore = 1'b1;
        @(posedge i_clock);
        #1;
        restore = 1'b0;
        @(posedge i_clock);
        #1;
        check(rot_time >= 32'h0002_84C8 && rot_time <= 32'h0003_0D40, 1'b1);
        c0 = tokens;
        inj_frame(COPY_PREAMBLE, 0);
        check(tokens - c0, 1);
        c0 = sofs;
        inj_frame(4, 34);
        check(sofs - c0, 0);
        c0 = eofs;
        inj_frame(COPY_PREAMBLE, 34);
        check(eofs - c0, 1);
        check(fcs_ok, 1'b0);
        inj_frame(COPY_PREAMBLE, 2 * (INFO_MAX_BYTES + 17) + 2);
        check(long_seen, 1'b1);
        tally_and_finish();
    end
    initial begin
        #200000;
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
